// [include/adc_host_pkg.sv]
package adc_host_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned WR_LOW_MIN_NS   = 600;
  localparam int unsigned WR_TO_RD_MIN_NS = 600;
  localparam int unsigned RD_PHASE_NS     = 800;
  localparam int unsigned WR_LOW_MAX_NS   = 50000;
  localparam int unsigned ZERO_MIN_NS     = 500;
  localparam int unsigned WR_LOW_CYC   = (WR_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WR_RD_CYC    = (WR_TO_RD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RD_TIMEOUT_CYC = 2 * RD_PHASE_NS / CLK_PERIOD_NS;
  localparam int unsigned WR_MAX_CYC   = WR_LOW_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned ZERO_CYC     = (ZERO_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W        = 16;
  localparam logic [7:0]  RESULT_RESET = 8'h00;
endpackage : adc_host_pkg

// [rtl/adc_host.sv]
`timescale 1ns/1ps
//
// Overview of operation
// RULE1: mode output selects read-only or write-then-read
// RULE2: read-only: hold read low until data
// RULE3: read-only: completion low ends read
// RULE4: device times banks; host waits for data
// RULE5: device samples first 800 ns of read
// RULE6: write-then-read: write strobe starts conversion
// RULE7: device banks sample on write fall
// RULE8: host holds write low 600 ns minimum
// RULE9: host waits 600 ns before read low
// RULE10: device resets banks on read fall
// RULE11: interrupt use: wait completion low, then read
// RULE12: fast read after 600 ns allowed
// RULE13: stand-alone: read and select held low
// RULE14: write low never exceeds 50 us
// RULE15: 500 ns zeroing before next conversion
// RULE16: device flash banks of fifteen comparators
// RULE17: device banks alternate zero and compare
// RULE18: strobes only while select low
// RULE19: completion released on read or select rise
// RULE20: overrange sampled with result, always driven
// RULE21: result upper nibble then lower nibble
module adc_host
  import adc_host_pkg::*;
#(
  parameter int unsigned WR_MAX_CYCLES = WR_MAX_CYC,
  parameter int unsigned ZERO_CYCLES   = ZERO_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       start,
  input  wire logic       mode_wr_rd,
  input  wire logic       wait_int,
  input  wire logic       stand_alone,
  input  wire logic [7:0] result_bus,
  input  wire logic       int_n,
  input  wire logic       overrange_n,
  output logic            cs_n,
  output logic            wr_n,
  output logic            rd_n,
  output logic            mode_pin,
  output logic            busy,
  output logic            done,
  output logic [7:0]      result,
  output logic            overrange
);

  typedef enum {S_IDLE, S_WR, S_GAP, S_RD, S_LATCH, S_ZERO} state_e;
  state_e            state_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  wr_low_cnt_q;
  logic [2:0]        int_sync_q;
  logic              int_low;
  logic              mode_q;
  logic              sa_q;

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchroniser
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      int_sync_q <= 3'h7;
    end else begin
      int_sync_q <= {int_sync_q[1:0], int_n};
    end
  end
  assign int_low = (int_sync_q[2:1] == 2'b00);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= S_IDLE;
      cnt_q   <= '0;
      mode_q  <= 1'b0;
      sa_q    <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          cnt_q <= '0;
          if (start) begin
            mode_q  <= mode_wr_rd;
            sa_q    <= stand_alone & mode_wr_rd;
            state_q <= mode_wr_rd ? S_WR : S_RD; // RULE6 RULE2
          end
        end
        S_WR: begin
          cnt_q <= cnt_q + 1'b1;
          // RULE8 RULE14
          if (cnt_q + 1'b1 >= CNT_W'(WR_LOW_CYC) || cnt_q + 1'b1 >= CNT_W'(WR_MAX_CYCLES)) begin
            cnt_q   <= '0;
            state_q <= S_GAP; // RULE17
          end
        end
        S_GAP: begin
          cnt_q <= cnt_q + 1'b1;
          if (sa_q) begin
            if (cnt_q + 1'b1 >= CNT_W'(RD_TIMEOUT_CYC / 2)) begin // RULE13
              state_q <= S_LATCH;
            end
          end else if (cnt_q + 1'b1 >= CNT_W'(WR_RD_CYC) && (!wait_int || int_low)) begin
            cnt_q   <= '0;
            state_q <= S_RD; // RULE9 RULE11 RULE12
          end
        end
        S_RD: begin
          cnt_q <= cnt_q + 1'b1;
          // RULE3 RULE4 RULE5
          if (int_low || (!mode_q && cnt_q + 1'b1 >= CNT_W'(RD_TIMEOUT_CYC))) begin
            state_q <= S_LATCH;
          end
        end
        S_LATCH: begin
          cnt_q   <= '0;
          state_q <= S_ZERO;
        end
        S_ZERO: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q + 1'b1 >= CNT_W'(ZERO_CYCLES)) begin
            state_q <= S_IDLE; // RULE15
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cs_n     <= 1'b1;
      wr_n     <= 1'b1;
      rd_n     <= 1'b1;
      mode_pin <= 1'b0;
      busy     <= 1'b0;
    end else begin
      mode_pin <= (state_q == S_IDLE) ? mode_wr_rd : mode_q; // RULE1
      busy     <= (state_q != S_IDLE) || start;
      // RULE18 RULE19
      cs_n <= !(((state_q == S_IDLE) && start) || (state_q == S_WR)
                || (state_q == S_GAP) || (state_q == S_RD) || sa_q);
      wr_n <= !(((state_q == S_IDLE) && start && mode_wr_rd) // RULE7
                || ((state_q == S_WR) && !(cnt_q + 1'b1 >= CNT_W'(WR_LOW_CYC)
                || cnt_q + 1'b1 >= CNT_W'(WR_MAX_CYCLES))));
      rd_n <= !(((state_q == S_IDLE) && start && !mode_wr_rd)
                || (state_q == S_RD) || sa_q // RULE10
                || ((state_q == S_GAP) && !sa_q && cnt_q + 1'b1 >= CNT_W'(WR_RD_CYC)
                    && (!wait_int || int_low)));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result capture
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done      <= 1'b0;
      result    <= RESULT_RESET;
      overrange <= 1'b0;
    end else begin
      done <= (state_q == S_LATCH);
      if (state_q == S_LATCH) begin
        result    <= result_bus;   // RULE21 RULE16
        overrange <= !overrange_n; // RULE20
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_wr_min;
    @(posedge clk) disable iff (!reset_n)
      $fell(wr_n) |-> !wr_n [*8];
  endproperty
  a_wr_min: assert property (p_wr_min) else $error("write low too short"); // RULE8

  property p_rd_gap;
    @(posedge clk) disable iff (!reset_n)
      $rose(wr_n) && !sa_q |-> rd_n [*8];
  endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("read too soon after write"); // RULE9

  property p_cs_strobe;
    @(posedge clk) disable iff (!reset_n)
      (!wr_n || !rd_n) |-> !cs_n;
  endproperty
  a_cs_strobe: assert property (p_cs_strobe) else $error("strobe without select"); // RULE18

  property p_zero;
    @(posedge clk) disable iff (!reset_n)
      done |-> (state_q != S_WR && state_q != S_RD) [*8];
  endproperty
  a_zero: assert property (p_zero) else $error("restart before zeroing"); // RULE15

  property p_done;
    @(posedge clk) disable iff (!reset_n)
      $rose(state_q == S_LATCH) |=> done;
  endproperty
  a_done: assert property (p_done) else $error("done missing"); // RULE3

  // helper count of cycles with write held low
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_low_cnt_q <= '0;
    end else if (wr_n) begin
      wr_low_cnt_q <= '0;
    end else begin
      wr_low_cnt_q <= wr_low_cnt_q + 1'b1;
    end
  end

  property p_wr_max;
    @(posedge clk) disable iff (!reset_n)
      !wr_n |-> (wr_low_cnt_q < CNT_W'(WR_MAX_CYCLES));
  endproperty
  a_wr_max: assert property (p_wr_max) else $error("write low too long"); // RULE14

  property p_rd_hold;
    @(posedge clk) disable iff (!reset_n)
      (state_q == S_RD) && !int_low && !$fell(rd_n) && $past(state_q == S_RD) |-> !rd_n;
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read released early"); // RULE2

  property p_mode;
    @(posedge clk) disable iff (!reset_n)
      (state_q == S_WR) |-> ##1 mode_pin;
  endproperty
  a_mode: assert property (p_mode) else $error("mode pin wrong"); // RULE1

endmodule : adc_host

// [verification/adc_dev_model.sv]
`timescale 1ns/1ps
module adc_dev_model
  import adc_host_pkg::*;
(
  input  wire logic       cs_n,
  input  wire logic       wr_n,
  input  wire logic       rd_n,
  input  wire logic       mode_pin,
  input  wire logic [8:0] analog,
  output logic [7:0]      result_bus,
  output logic            int_n,
  output logic            overrange_n,
  output int              faults
);
  realtime t_fall, t_rise, t_end, t_mark;
  logic    ready;
  initial begin
    int_n  = 1'b1;
    ready  = 1'b0;
    faults = 0;
    t_end  = -1.0e6;
  end
  // bus shows inverse data when not read
  assign result_bus  = (!cs_n && !rd_n && ready) ? analog[7:0] : ~analog[7:0];
  assign overrange_n = ready ? ~analog[8] : 1'b1;
  always @(negedge wr_n) if (!cs_n && mode_pin) begin
    t_fall = $realtime;
    if (t_fall - t_end < ZERO_MIN_NS) faults++;
    ready = 1'b0;
    int_n = 1'b1;
  end
  always @(posedge wr_n) if (!cs_n && mode_pin) begin
    t_rise = $realtime;
    t_mark = t_rise;
    if (t_rise - t_fall < WR_LOW_MIN_NS || t_rise - t_fall > WR_LOW_MAX_NS) faults++;
    #(RD_PHASE_NS);
    if (t_mark == t_rise && !ready) begin
      ready = 1'b1;
      int_n = 1'b0;
      t_end = $realtime;
    end
  end
  always @(negedge rd_n) if (!cs_n) begin
    if (mode_pin) begin
      // read falling during write low is stand-alone: data follows the write
      if (wr_n) begin
        if ($realtime - t_rise < WR_TO_RD_MIN_NS) faults++;
        ready = 1'b1;
        int_n = 1'b0;
        t_end = $realtime;
      end
    end else begin
      ready = 1'b0;
      #(2 * RD_PHASE_NS);
      ready = 1'b1;
      int_n = 1'b0;
      t_end = $realtime;
    end
  end
  always @(posedge rd_n or posedge cs_n) int_n = 1'b1;
endmodule : adc_dev_model

// [verification/half_flash_adc_conversion_control_tb_top.sv]
`timescale 1ns/1ps
module half_flash_adc_conversion_control_tb_top
  import adc_host_pkg::*;
;
  logic clk = 0, reset_n = 0, start = 0, mode_wr_rd = 0, wait_int = 0, stand_alone = 0;
  logic cs_n, wr_n, rd_n, mode_pin, busy, done, overrange, int_n, overrange_n;
  logic [7:0] result, result_bus;
  logic [8:0] analog = 9'h000;
  int         faults, mismatches = 0, compares = 0;
  always #5 clk = ~clk;
  adc_host #(.WR_MAX_CYCLES(100), .ZERO_CYCLES(50)) u_dut (.clk(clk), .reset_n(reset_n),
    .start(start), .mode_wr_rd(mode_wr_rd), .wait_int(wait_int), .stand_alone(stand_alone),
    .result_bus(result_bus), .int_n(int_n), .overrange_n(overrange_n), .cs_n(cs_n),
    .wr_n(wr_n), .rd_n(rd_n), .mode_pin(mode_pin), .busy(busy), .done(done),
    .result(result), .overrange(overrange));
  adc_dev_model u_dev (.cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .mode_pin(mode_pin),
    .analog(analog), .result_bus(result_bus), .int_n(int_n), .overrange_n(overrange_n),
    .faults(faults));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] seen);
    compares++;
    if (exp !== seen) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  // one conversion, judged at the done pulse
  task automatic run_conv(input logic m, input logic w, input logic s, input logic [8:0] v);
    int n;
    analog = v;
    @(negedge clk);
    {mode_wr_rd, wait_int, stand_alone, start} = {m, w, s, 1'b1};
    @(negedge clk);
    start = 1'b0;
    @(negedge clk);
    check("mode_pin", m, mode_pin);
    check("busy", 1, busy);
    for (n = 0; n < 3000 && done !== 1'b1; n++) @(negedge clk);
    if (n == 3000) begin
      mismatches++;
      finish_test();
    end
    check("result", v[7:0], result);
    check("overrange", v[8], overrange);
    @(negedge clk);
    check("done_pulse", 0, done);
    repeat (60) @(negedge clk);
    check("host_faults", 0, faults[8:0]);
    check("busy_idle", 0, busy);
  endtask : run_conv
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_rd_mode();
    run_conv(1'b0, 1'b0, 1'b0, 9'h0a5);
  endtask : t_rd_mode
  task automatic t_wr_int();
    run_conv(1'b1, 1'b1, 1'b0, 9'h13c);
  endtask : t_wr_int
  task automatic t_wr_fast();
    run_conv(1'b1, 1'b0, 1'b0, 9'h0f0);
    run_conv(1'b1, 1'b0, 1'b0, 9'h00f);
  endtask : t_wr_fast
  task automatic t_stand_alone();
    run_conv(1'b1, 1'b0, 1'b1, 9'h05a);
  endtask : t_stand_alone
  initial begin
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    check("cs_n_idle", 1, cs_n);
    t_rd_mode();
    t_wr_int();
    t_wr_fast();
    t_stand_alone();
    finish_test();
  end
endmodule : half_flash_adc_conversion_control_tb_top
